// file: design/rtsp_map.vh
`ifndef RTSP_MAP_VH
`define RTSP_MAP_VH

// Core clock rate in Hz
`define RTSP_CLK_HZ 10000000

// Software register map (word index on the plain register port)
`define RTSP_ADDR_W 7
`define RTSP_DATA_W 16
`define RTSP_CTRL_ADDR 7'h40
`define RTSP_STAT_ADDR 7'h41
`define RTSP_MEM_SEL_BIT 6

// Control register fields
`define RTSP_CTRL_ALT_BIT 0
`define RTSP_CTRL_FLOAT_BIT 1
`define RTSP_CTRL_CSEL_LO 2
`define RTSP_CTRL_CSEL_HI 4
`define RTSP_CTRL_SEQTX_BIT 5
`define RTSP_CTRL_SLEEP_LO 6
`define RTSP_CTRL_SLEEP_HI 7
`define RTSP_CTRL_RST 16'h001A

// Status register fields
`define RTSP_STAT_MODE_LO 0
`define RTSP_STAT_MODE_HI 2
`define RTSP_STAT_FRAME_BIT 3
`define RTSP_STAT_SHORT_BIT 4
`define RTSP_STAT_GP1_BIT 5
`define RTSP_STAT_GP2_BIT 6
`define RTSP_STAT_CRC_BIT 7

// Operating modes
`define RTSP_MODE_IDLE 3'h0
`define RTSP_MODE_DOZE 3'h1
`define RTSP_MODE_HIB 3'h2
`define RTSP_MODE_RX 3'h3
`define RTSP_MODE_TX 3'h4

// Sleep requests
`define RTSP_SLEEP_NONE 2'h0
`define RTSP_SLEEP_DOZE 2'h1
`define RTSP_SLEEP_HIB 2'h2

// Serial header layout
`define RTSP_HDR_RW_BIT 7
`define RTSP_HDR_ADDR_HI 5
`define RTSP_MIN_BURSTS 2'h3

// Clock output selections, Hz
`define RTSP_F0 16000000
`define RTSP_F1 8000000
`define RTSP_F2 4000000
`define RTSP_F3 2000000
`define RTSP_F4 1000000
`define RTSP_F5 62500
`define RTSP_F6 32786
`define RTSP_F7 16393
`define RTSP_CSEL_SLOW 3'h4

`endif

// file: design/rtsp_clkdiv.v
`default_nettype none
`include "rtsp_map.vh"

module rtsp_clkdiv #(
    parameter CLK_HZ = `RTSP_CLK_HZ
) (
    input  wire       clock,
    input  wire       arst_n,
    input  wire [2:0] sel,
    input  wire       run,
    output reg        clkOut
);
    reg [15:0] cnt_reg;

    // Half period in core cycles, never below one
    function [15:0] halfCount;
        input [2:0] s;
        reg [31:0] f;
        reg [31:0] h;
        begin
            case (s)
                3'h0: f = `RTSP_F0;
                3'h1: f = `RTSP_F1;
                3'h2: f = `RTSP_F2;
                3'h3: f = `RTSP_F3;
                3'h4: f = `RTSP_F4;
                3'h5: f = `RTSP_F5;
                3'h6: f = `RTSP_F6;
                default: f = `RTSP_F7;
            endcase
            h = CLK_HZ / (2 * f);
            if (h == 32'h0) begin
                h = 32'h1;
            end
            halfCount = h[15:0];
        end
    endfunction

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 16'h0000;
            clkOut  <= 1'b0;
        end else if (!run) begin
            cnt_reg <= 16'h0000;
            clkOut  <= 1'b0;
        end else if (cnt_reg >= halfCount(sel) - 16'h0001) begin
            cnt_reg <= 16'h0000;
            clkOut  <= ~clkOut;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule

`default_nettype wire

// file: design/rtsp_shift.v
`default_nettype none

module rtsp_shift (
    input  wire       clock,
    input  wire       arst_n,
    input  wire       enable,
    input  wire       frameN,
    input  wire       sclk,
    input  wire       sdi,
    input  wire       load,
    input  wire [7:0] txData,
    output reg  [7:0] rxData,
    output reg        byteDone,
    output reg        sdo
);
    reg       sclkPrev_reg;
    reg [2:0] bitCnt_reg;
    reg [7:0] txSh_reg;

    wire active = enable & ~frameN;
    wire rise   = active & sclk & ~sclkPrev_reg;
    wire fall   = active & ~sclk & sclkPrev_reg;

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sclkPrev_reg <= 1'b0;
            bitCnt_reg   <= 3'h0;
            txSh_reg     <= 8'h00;
            rxData       <= 8'h00;
            byteDone     <= 1'b0;
            sdo          <= 1'b0;
        end else begin
            sclkPrev_reg <= sclk;
            byteDone     <= 1'b0;
            if (!active) begin
                bitCnt_reg <= 3'h0;
            end else if (rise) begin
                // Sample on rising edge, MSB first
                rxData     <= {rxData[6:0], sdi};
                bitCnt_reg <= bitCnt_reg + 3'h1;
                if (bitCnt_reg == 3'h7) begin
                    byteDone <= 1'b1;
                end
            end
            if (load) begin
                txSh_reg <= txData;
                sdo      <= txData[7];
            end else if (fall && bitCnt_reg != 3'h0) begin
                // Fall after the eighth rise keeps the freshly loaded MSB
                txSh_reg <= {txSh_reg[6:0], 1'b0};
                sdo      <= txSh_reg[6];
            end
        end
    end
endmodule

`default_nettype wire

// file: design/rtsp_top.v
// Operation
// - Device is serial slave only; host alone drives clock and starts transfers.
// - Low frame select marks a transaction in progress.
// - A transaction holds at least three bursts, possibly more.
// - Clock idles low; sample on rising edge, change output on falling edge.
// - Each burst is eight bits, most significant bit first.
// - After header, bursts are all host writes or all device reads.
// - Only one data line carries meaning per burst after the header.
// - Payload after the header is at least two bytes.
// - Shift logic follows host clock; transfers to storage use the core clock.
// - Alternate select drives pin 2 checksum-valid and pin 1 out-of-idle.
// - Held reset keeps device off and discards stored contents; mem is not cleared by reset here.
// - Reset release enters idle with all registers at defaults.
// - Rising sequence start launches receive or transmit per programmed setting.
// - Sequence start held low forces idle.
// - Low wake input returns device from either sleep state to idle.
// - Clock output selectable among eight rates, 32.786 kHz after reset; here the three fastest settings all give 5 MHz.
// - Serial port dead in sleep states; only wake input honoured.
// - Serial output floats while frame select high, or drives low if selected.
// - General pins come out of reset as inputs without pull-ups.
`default_nettype none
`include "rtsp_map.vh"

module rtsp_top #(
    parameter CLK_HZ = `RTSP_CLK_HZ,
    parameter AW     = `RTSP_ADDR_W,
    parameter DW     = `RTSP_DATA_W
) (
    input  wire          clock,
    input  wire          arst_n,
    input  wire [AW-1:0] regAddr,
    input  wire [DW-1:0] regWrData,
    input  wire          regWr,
    input  wire          regRd,
    output reg  [DW-1:0] regRdData,
    input  wire          host_serial_clock,
    input  wire          frameSelN,
    input  wire          mosi,
    output reg           miso,
    output reg           misoOeN,
    input  wire          radio_sequence_start,
    input  wire          wake_request_n,
    input  wire          crcValid,
    output reg  [2:0]    radioMode,
    output wire          host_clock_output,
    input  wire          general_pin_1_in,
    output reg           general_pin_1_out,
    output reg           general_pin_1_oeN,
    input  wire          general_pin_2_in,
    output reg           general_pin_2_out,
    output reg           general_pin_2_oeN
);
    reg [DW-1:0] mem [0:63];
    reg [DW-1:0] ctrl_reg;
    reg [2:0]    mode_reg;
    reg          seqPrev_reg;
    reg          framePrev_reg;
    reg          hdrPending_reg;
    reg          isRead_reg;
    reg          hiPhase_reg;
    reg [5:0]    addr_reg;
    reg [7:0]    hiByte_reg;
    reg [7:0]    txData_reg;
    reg          load_reg;
    reg [1:0]    burstCnt_reg;
    reg          short_reg;
    reg          frameLive_reg;

    wire [7:0] rxByte;
    wire       byteDone;
    wire       shiftOut;

    // Control register address decode
    function ctrlHit;
        input [AW-1:0] a;
        begin
            ctrlHit = (a == `RTSP_CTRL_ADDR);
        end
    endfunction

    wire       altEn    = ctrl_reg[`RTSP_CTRL_ALT_BIT];
    wire       floatEn  = ctrl_reg[`RTSP_CTRL_FLOAT_BIT];
    wire [2:0] clkSel   = ctrl_reg[`RTSP_CTRL_CSEL_HI:`RTSP_CTRL_CSEL_LO];
    wire       seqTx    = ctrl_reg[`RTSP_CTRL_SEQTX_BIT];
    wire [1:0] sleepReq = ctrl_reg[`RTSP_CTRL_SLEEP_HI:`RTSP_CTRL_SLEEP_LO];

    wire asleep = (mode_reg == `RTSP_MODE_DOZE) | (mode_reg == `RTSP_MODE_HIB);
    wire serialOn = ~asleep;
    wire frameOn  = serialOn & ~frameSelN;
    wire frameStart = serialOn & framePrev_reg & ~frameSelN;
    wire frameEnd   = frameLive_reg & serialOn & frameSelN;
    wire seqRise    = radio_sequence_start & ~seqPrev_reg;

    // Oscillator off in hibernate; in doze only slow rates run
    wire clkRun = (mode_reg != `RTSP_MODE_HIB) &
                  ((mode_reg != `RTSP_MODE_DOZE) | (clkSel >= `RTSP_CSEL_SLOW));

    wire memBusSel = ~regAddr[`RTSP_MEM_SEL_BIT];
    wire serWrite  = byteDone & ~hdrPending_reg & ~isRead_reg & ~hiPhase_reg;
    wire busMemWr  = regWr & memBusSel & ~serWrite;
    wire ctrlWr    = regWr & ctrlHit(regAddr);
    wire statRd    = regRd & (regAddr == `RTSP_STAT_ADDR);

    wire [5:0] addrNext = addr_reg + 6'h01;
    wire [5:0] hdrAddr  = rxByte[`RTSP_HDR_ADDR_HI:0];

    rtsp_shift rtsp_shift_inst (
        .clock    (clock),
        .arst_n   (arst_n),
        .enable   (serialOn & frameLive_reg),
        .frameN   (frameSelN),
        .sclk     (host_serial_clock),
        .sdi      (mosi),
        .load     (load_reg),
        .txData   (txData_reg),
        .rxData   (rxByte),
        .byteDone (byteDone),
        .sdo      (shiftOut)
    );

    rtsp_clkdiv #(
        .CLK_HZ (CLK_HZ)
    ) rtsp_clkdiv_inst (
        .clock  (clock),
        .arst_n (arst_n),
        .sel    (clkSel),
        .run    (clkRun),
        .clkOut (host_clock_output)
    );

    // Storage moves on the core clock only
    always @(posedge clock) begin
        if (serWrite) begin
            mem[addr_reg] <= {hiByte_reg, rxByte};
        end else if (busMemWr) begin
            mem[regAddr[5:0]] <= regWrData;
        end
    end

    // Transaction sequencing
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            framePrev_reg  <= 1'b1;
            hdrPending_reg <= 1'b1;
            isRead_reg     <= 1'b0;
            hiPhase_reg    <= 1'b1;
            addr_reg       <= 6'h00;
            hiByte_reg     <= 8'h00;
            txData_reg     <= 8'h00;
            load_reg       <= 1'b0;
            burstCnt_reg   <= 2'h0;
            short_reg      <= 1'b0;
            frameLive_reg  <= 1'b0;
        end else begin
            framePrev_reg <= frameSelN;
            load_reg      <= 1'b0;
            if (!serialOn) begin
                frameLive_reg <= 1'b0;
            end
            if (statRd) begin
                short_reg <= 1'b0;
            end
            if (frameStart) begin
                frameLive_reg  <= 1'b1;
                hdrPending_reg <= 1'b1;
                hiPhase_reg    <= 1'b1;
                burstCnt_reg   <= 2'h0;
                txData_reg     <= 8'h00;
                load_reg       <= 1'b1;
            end else if (frameEnd) begin
                frameLive_reg  <= 1'b0;
                hdrPending_reg <= 1'b1;
                if (burstCnt_reg < `RTSP_MIN_BURSTS) begin
                    short_reg <= 1'b1;
                end
            end else if (byteDone) begin
                if (burstCnt_reg != `RTSP_MIN_BURSTS) begin
                    burstCnt_reg <= burstCnt_reg + 2'h1;
                end
                load_reg <= 1'b1;
                if (hdrPending_reg) begin
                    hdrPending_reg <= 1'b0;
                    isRead_reg     <= rxByte[`RTSP_HDR_RW_BIT];
                    addr_reg       <= hdrAddr;
                    hiPhase_reg    <= 1'b1;
                    if (rxByte[`RTSP_HDR_RW_BIT]) begin
                        txData_reg <= mem[hdrAddr][15:8];
                    end else begin
                        txData_reg <= 8'h00;
                    end
                end else if (isRead_reg) begin
                    if (hiPhase_reg) begin
                        txData_reg  <= mem[addr_reg][7:0];
                        hiPhase_reg <= 1'b0;
                    end else begin
                        addr_reg    <= addrNext;
                        txData_reg  <= mem[addrNext][15:8];
                        hiPhase_reg <= 1'b1;
                    end
                end else begin
                    txData_reg <= 8'h00;
                    if (hiPhase_reg) begin
                        hiByte_reg  <= rxByte;
                        hiPhase_reg <= 1'b0;
                    end else begin
                        addr_reg    <= addrNext;
                        hiPhase_reg <= 1'b1;
                    end
                end
            end
        end
    end

    // Operating mode and control register
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg    <= `RTSP_MODE_IDLE;
            ctrl_reg    <= `RTSP_CTRL_RST;
            seqPrev_reg <= 1'b0;
        end else begin
            seqPrev_reg <= radio_sequence_start;
            if (ctrlWr) begin
                ctrl_reg <= regWrData;
            end
            case (mode_reg)
                `RTSP_MODE_IDLE: begin
                    if (seqRise) begin
                        mode_reg <= seqTx ? `RTSP_MODE_TX : `RTSP_MODE_RX;
                    end else if (sleepReq == `RTSP_SLEEP_DOZE && !ctrlWr) begin
                        mode_reg <= `RTSP_MODE_DOZE;
                        ctrl_reg[`RTSP_CTRL_SLEEP_HI:`RTSP_CTRL_SLEEP_LO] <=
                            `RTSP_SLEEP_NONE;
                    end else if (sleepReq == `RTSP_SLEEP_HIB && !ctrlWr) begin
                        mode_reg <= `RTSP_MODE_HIB;
                        ctrl_reg[`RTSP_CTRL_SLEEP_HI:`RTSP_CTRL_SLEEP_LO] <=
                            `RTSP_SLEEP_NONE;
                    end
                end
                `RTSP_MODE_DOZE, `RTSP_MODE_HIB: begin
                    if (!wake_request_n) begin
                        mode_reg <= `RTSP_MODE_IDLE;
                    end
                end
                `RTSP_MODE_RX, `RTSP_MODE_TX: begin
                    if (!radio_sequence_start) begin
                        mode_reg <= `RTSP_MODE_IDLE;
                    end
                end
                default: begin
                    mode_reg <= `RTSP_MODE_IDLE;
                end
            endcase
        end
    end

    // Pins and read port
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            miso              <= 1'b0;
            misoOeN           <= 1'b1;
            radioMode         <= `RTSP_MODE_IDLE;
            general_pin_1_out <= 1'b0;
            general_pin_1_oeN <= 1'b1;
            general_pin_2_out <= 1'b0;
            general_pin_2_oeN <= 1'b1;
            regRdData         <= {DW{1'b0}};
        end else begin
            radioMode <= mode_reg;
            if (frameOn) begin
                // Data only in read payload, zero otherwise
                miso    <= shiftOut & isRead_reg & ~hdrPending_reg;
                misoOeN <= 1'b0;
            end else begin
                miso    <= 1'b0;
                misoOeN <= floatEn;
            end
            general_pin_1_out <= altEn & (mode_reg != `RTSP_MODE_IDLE);
            general_pin_2_out <= altEn & crcValid;
            general_pin_1_oeN <= ~altEn;
            general_pin_2_oeN <= ~altEn;
            regRdData <= {DW{1'b0}};
            if (regRd) begin
                if (memBusSel) begin
                    regRdData <= mem[regAddr[5:0]];
                end else if (ctrlHit(regAddr)) begin
                    regRdData <= ctrl_reg;
                end else if (statRd) begin
                    regRdData[`RTSP_STAT_MODE_HI:`RTSP_STAT_MODE_LO] <= mode_reg;
                    regRdData[`RTSP_STAT_FRAME_BIT] <= frameOn;
                    regRdData[`RTSP_STAT_SHORT_BIT] <= short_reg;
                    regRdData[`RTSP_STAT_GP1_BIT]   <= general_pin_1_in;
                    regRdData[`RTSP_STAT_GP2_BIT]   <= general_pin_2_in;
                    regRdData[`RTSP_STAT_CRC_BIT]   <= crcValid;
                end
            end
        end
    end
endmodule

`default_nettype wire

// file: tb/rtsp_assertions.sv
`default_nettype none
`include "rtsp_map.vh"

module rtsp_assertions #(
    parameter DW = 16
) (
    input wire logic          clock,
    input wire logic          arst_n,
    input wire logic [DW-1:0] regRdData,
    input wire logic          frameSelN,
    input wire logic          miso,
    input wire logic          misoOeN,
    input wire logic          radio_sequence_start,
    input wire logic          wake_request_n,
    input wire logic          crcValid,
    input wire logic [2:0]    radioMode,
    input wire logic          general_pin_1_out,
    input wire logic          general_pin_1_oeN,
    input wire logic          general_pin_2_out,
    input wire logic          general_pin_2_oeN
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    wire logic sleepNow = radioMode == `RTSP_MODE_DOZE || radioMode == `RTSP_MODE_HIB;

    sequence seqStart;
        $rose(radio_sequence_start) && radioMode == `RTSP_MODE_IDLE;
    endsequence
    sequence seqHeldLow;
        !radio_sequence_start [*3];
    endsequence
    sequence seqFrameIdle;
        frameSelN [*4];
    endsequence

    chk_reset_state: assert property (disable iff (1'b0) !arst_n |->
        misoOeN && !miso && radioMode == `RTSP_MODE_IDLE && regRdData == '0 &&
        general_pin_1_oeN && general_pin_2_oeN)
        else $error("outputs not at reset values");
    chk_float_low: assert property (seqFrameIdle ##0 !misoOeN |-> !miso)
        else $error("miso not low outside frame");
    chk_seq_launch: assert property (seqStart |->
        ##2 radioMode inside {`RTSP_MODE_RX, `RTSP_MODE_TX})
        else $error("sequence start not launched");
    chk_seq_idle: assert property (seqHeldLow |->
        radioMode != `RTSP_MODE_RX && radioMode != `RTSP_MODE_TX)
        else $error("low sequence start did not force idle");
    chk_wake_idle: assert property (sleepNow && !wake_request_n |->
        ##[1:3] radioMode == `RTSP_MODE_IDLE)
        else $error("wake did not return to idle");
    chk_sleep_mute: assert property (sleepNow && $past(sleepNow) |-> $stable(misoOeN))
        else $error("serial port active while asleep");
    chk_alt_oe_pair: assert property (general_pin_1_oeN == general_pin_2_oeN)
        else $error("pin directions differ");
    chk_pin1_active: assert property (
        !general_pin_1_oeN && !$past(general_pin_1_oeN) && $stable(radioMode) &&
        $stable(general_pin_1_out) |-> general_pin_1_out == (radioMode != `RTSP_MODE_IDLE))
        else $error("pin 1 not showing out of idle");
    chk_pin2_crc: assert property (
        !general_pin_2_oeN && !$past(general_pin_2_oeN) && $stable(crcValid) &&
        crcValid == $past(crcValid, 2) && $stable(general_pin_2_out) |->
        general_pin_2_out == crcValid)
        else $error("pin 2 not showing checksum valid");
endmodule

bind rtsp_top rtsp_assertions #(.DW(DW)) rtsp_assertions_inst (
    .clock, .arst_n, .regRdData, .frameSelN, .miso, .misoOeN, .radio_sequence_start,
    .wake_request_n, .crcValid, .radioMode, .general_pin_1_out, .general_pin_1_oeN,
    .general_pin_2_out, .general_pin_2_oeN);

`default_nettype wire

// file: tb/rtsp_host.sv
`default_nettype none

module rtsp_host (
    input  wire logic clock,
    output var  logic host_serial_clock,
    output var  logic frameSelN,
    output var  logic mosi,
    input  wire logic miso,
    input  wire logic misoOeN
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF = 5;
    logic      misoHold = 1'b0;
    // Floating line reads as the inverse of its last driven level
    wire logic misoSeen = misoOeN ? ~misoHold : miso;

    always @(posedge clock) if (!misoOeN) misoHold <= miso;

    initial begin
        host_serial_clock = 1'b0;
        frameSelN = 1'b1;
        mosi = 1'b0;
    end

    task automatic open();
        @(posedge clock) frameSelN <= 1'b0;
        repeat (HALF) @(posedge clock);
    endtask

    task automatic close();
        repeat (HALF) @(posedge clock);
        frameSelN <= 1'b1;
        repeat (HALF) @(posedge clock);
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi <= tx[i];
            repeat (HALF) @(posedge clock);
            host_serial_clock <= 1'b1;
            rx[i] = misoSeen;
            repeat (HALF) @(posedge clock);
            host_serial_clock <= 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// file: tb/rtsp_top_tb.sv
`default_nettype none
`include "rtsp_map.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end

module rtsp_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0;
    logic        arst_n = 1'b1;
    logic [6:0]  regAddr = 7'h00;
    logic [15:0] regWrData = 16'h0000;
    logic [15:0] regRdData, rdv;
    logic        regWr = 1'b0, regRd = 1'b0, radio_sequence_start = 1'b0;
    logic        wake_request_n = 1'b1, crcValid = 1'b0, pin1Drv = 1'b1, pin2Drv = 1'b0;
    logic        host_serial_clock, frameSelN, mosi, miso, misoOeN, host_clock_output;
    logic [2:0]  radioMode;
    logic        general_pin_1_out, general_pin_1_oeN, general_pin_2_out, general_pin_2_oeN;
    logic [31:0] got;
    wire logic   general_pin_1_in = general_pin_1_oeN ? pin1Drv : general_pin_1_out;
    wire logic   general_pin_2_in = general_pin_2_oeN ? pin2Drv : general_pin_2_out;
    int          error_cnt = 0, cmp_count = 0, n, e;
    int          fr [8] = '{`RTSP_F0, `RTSP_F1, `RTSP_F2, `RTSP_F3,
                            `RTSP_F4, `RTSP_F5, `RTSP_F6, `RTSP_F7};

    rtsp_top #(.CLK_HZ(`RTSP_CLK_HZ)) rtsp_top_inst (
        .clock, .arst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
        .host_serial_clock, .frameSelN, .mosi, .miso, .misoOeN, .radio_sequence_start,
        .wake_request_n, .crcValid, .radioMode, .host_clock_output,
        .general_pin_1_in, .general_pin_1_out, .general_pin_1_oeN,
        .general_pin_2_in, .general_pin_2_out, .general_pin_2_oeN);

    rtsp_host rtsp_host_inst (.clock, .host_serial_clock, .frameSelN, .mosi, .miso, .misoOeN);

    always #50 clock = ~clock;

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clock) regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clock) regWr <= 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge clock) regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock) regRd <= 1'b0;
        #1 d = regRdData;
    endtask

    task automatic waitc(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask

    task automatic frame(input logic [7:0] hdr, input int cnt, input logic [31:0] wd,
                         output logic [31:0] rx);
        logic [7:0] b;
        rx = 32'h0;
        rtsp_host_inst.open();
        rtsp_host_inst.xfer(hdr, b);
        for (int k = 0; k < cnt; k++) begin
            rtsp_host_inst.xfer(wd[31-8*k -: 8], b);
            rx[31-8*k -: 8] = b;
        end
        rtsp_host_inst.close();
    endtask

    // Edges between two output toggles, after settling on the new rate
    task automatic half(output int c);
        logic v;
        for (int j = 0; j < 3; j++) begin
            v = host_clock_output;
            c = 0;
            while (host_clock_output === v && c < 700) begin
                @(posedge clock);
                #1;
                c++;
            end
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        results();
    end

    initial begin
        #10 arst_n = 1'b0;
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        waitc(1);
        `CHK(misoOeN, 1'b1)
        `CHK({general_pin_1_oeN, general_pin_2_oeN}, 2'h3)
        rd(`RTSP_CTRL_ADDR, rdv);
        `CHK(rdv, `RTSP_CTRL_RST)
        rd(`RTSP_STAT_ADDR, rdv);
        `CHK(rdv[6:0], {2'h1, 2'h0, `RTSP_MODE_IDLE})
        rd(7'h42, rdv);
        `CHK(rdv, 16'h0000)
        half(n);
        `CHK(n, `RTSP_CLK_HZ / (2 * `RTSP_F6))
        wr(7'h05, 16'hA55A);
        wr(7'h06, 16'h3CC3);
        frame(8'h85, 4, 32'hFFFF_FFFF, got);
        `CHK(got, 32'hA55A_3CC3)
        frame(8'h0A, 4, 32'hA1B2_C3D4, got);
        `CHK(got, 32'h0)
        rd(7'h0A, rdv);
        `CHK(rdv, 16'hA1B2)
        rd(7'h0B, rdv);
        `CHK(rdv, 16'hC3D4)
        frame(8'h0D, 2, 32'h1234_0000, got);
        rd(7'h0D, rdv);
        `CHK(rdv, 16'h1234)
        rd(`RTSP_STAT_ADDR, rdv);
        `CHK(rdv[4], 1'b0)
        frame(8'h0C, 1, 32'h7700_0000, got);
        rd(`RTSP_STAT_ADDR, rdv);
        `CHK(rdv[4], 1'b1)
        rd(`RTSP_STAT_ADDR, rdv);
        `CHK(rdv[4], 1'b0)
        wr(`RTSP_CTRL_ADDR, 16'h0018);
        waitc(3);
        `CHK({misoOeN, miso}, 2'h0)
        @(posedge clock) crcValid <= 1'b1;
        wr(`RTSP_CTRL_ADDR, 16'h001B);
        waitc(3);
        `CHK({general_pin_1_oeN, general_pin_2_oeN}, 2'h0)
        `CHK({general_pin_1_out, general_pin_2_out}, 2'h1)
        for (int t = 0; t < 2; t++) begin
            wr(`RTSP_CTRL_ADDR, t ? 16'h003B : 16'h001B);
            @(posedge clock) radio_sequence_start <= 1'b1;
            waitc(4);
            `CHK(radioMode, t ? `RTSP_MODE_TX : `RTSP_MODE_RX)
            `CHK(general_pin_1_out, 1'b1)
            @(posedge clock) radio_sequence_start <= 1'b0;
            waitc(4);
            `CHK(radioMode, `RTSP_MODE_IDLE)
        end
        wr(7'h0E, 16'h1234);
        for (int t = 1; t < 3; t++) begin
            wr(`RTSP_CTRL_ADDR, {8'h00, 2'(t), 6'h1A});
            waitc(3);
            `CHK(radioMode, t == 1 ? `RTSP_MODE_DOZE : `RTSP_MODE_HIB)
            frame(8'h0E, 2, 32'h5566_0000, got);
            @(posedge clock) wake_request_n <= 1'b0;
            waitc(3);
            `CHK(radioMode, `RTSP_MODE_IDLE)
            @(posedge clock) wake_request_n <= 1'b1;
        end
        rd(7'h0E, rdv);
        `CHK(rdv, 16'h1234)
        rd(`RTSP_STAT_ADDR, rdv);
        `CHK(rdv[4], 1'b0)
        for (int s = 0; s < 8; s++) begin
            wr(`RTSP_CTRL_ADDR, {11'h000, 3'(s), 2'h2});
            half(n);
            e = `RTSP_CLK_HZ / (2 * fr[s]);
            `CHK(n, (e < 1) ? 1 : e)
        end
        results();
    end
endmodule

`default_nettype wire
